// file: design/gmc_top.sv
// Purpose: Free-run / genlock mode control for the first-stage clock loop
// Assumes: Reference presence and loop lock detectors feed level inputs
// Notes: Registers over APB; analog switches driven as digital controls
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gmc_top #(
    parameter int FLAG_STABLE_CYC = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LOCK_MODE_SELECT_PIN,
    input wire logic REF_PRESENT,
    input wire logic LOOP_LOCKED,
    output logic BIAS_SWITCH_ON,
    output logic LOOP_FILTER_HIZ,
    output logic PFD_ENABLE,
    output logic ALIGN_ENABLE,
    output logic REF_MISSING,
    output logic LOCK_MISSING
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic eff_mode;
    logic ref_missing_f;
    logic lock_missing_f;
    gmc_pkg::gmc_state_t state_q;
    gmc_pkg::gmc_state_t state_d;

    // One wait state: answer in the cycle after the first access-phase cycle
    always_comb
    begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (PSEL && PENABLE && !pready_q)
        begin
            pready_d = 1'b1;
            case (PADDR)
                gmc_pkg::GMC_OFS_CTRL:
                begin
                    if (PWRITE)
                        ctrl_d = PWDATA[7:0];
                    else
                        prdata_d = {24'h000000, ctrl_q};
                end
                gmc_pkg::GMC_OFS_STAT:
                begin
                    if (PWRITE)
                        pslverr_d = 1'b1; // Status is read only
                    else
                        prdata_d = {24'h000000, 2'h0, ref_missing_f, lock_missing_f,
                                    eff_mode, 3'(state_q)};
                end
                default:
                begin
                    pslverr_d = 1'b1; // Unmapped address
                    prdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_q <= gmc_pkg::GMC_CTRL_RST;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ****************************************************************
    // Mode resolution
    // ****************************************************************
    // Mode source picks register bit or pin
    assign eff_mode = ctrl_q[gmc_pkg::GMC_CTRL_SRC_BIT] ? ctrl_q[gmc_pkg::GMC_CTRL_MODE_BIT]
                                                         : LOCK_MODE_SELECT_PIN;

    // ****************************************************************
    // Genlock state machine
    // ****************************************************************
    // Reference presence is trusted as-is; no stability qualifier
    always_comb
    begin
        state_d = state_q;
        if (!eff_mode)
            state_d = gmc_pkg::GMC_FREE_MODE;
        else
        begin
            case (state_q)
                // Entering genlock with no reference goes straight to loss handling,
                // so the phase detector never pulses for a cycle on an absent input
                gmc_pkg::GMC_FREE_MODE:
                begin
                    if (!REF_PRESENT)
                        state_d = ctrl_q[gmc_pkg::GMC_CTRL_HOLD_BIT] ? gmc_pkg::GMC_LOR_HOLD
                                                                   : gmc_pkg::GMC_LOR_FREE;
                    else
                        state_d = gmc_pkg::GMC_ACQUIRE;
                end
                gmc_pkg::GMC_ACQUIRE, gmc_pkg::GMC_LOCKED:
                begin
                    if (!REF_PRESENT)
                        state_d = ctrl_q[gmc_pkg::GMC_CTRL_HOLD_BIT] ? gmc_pkg::GMC_LOR_HOLD
                                                                   : gmc_pkg::GMC_LOR_FREE;
                    else if (LOOP_LOCKED)
                        state_d = gmc_pkg::GMC_LOCKED;
                    else
                        state_d = gmc_pkg::GMC_ACQUIRE;
                end
                gmc_pkg::GMC_LOR_FREE, gmc_pkg::GMC_LOR_HOLD:
                begin
                    if (REF_PRESENT)
                        state_d = gmc_pkg::GMC_ACQUIRE;
                end
                default:
                    state_d = gmc_pkg::GMC_FREE_MODE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_q <= gmc_pkg::GMC_FREE_MODE;
        else
            state_q <= state_d;
    end

    // ****************************************************************
    // Loop controls and flags
    // ****************************************************************
    gmc_pkg::gmc_loop_ctl_t ctl_q;
    gmc_pkg::gmc_loop_ctl_t ctl_d;
    logic ref_missing_raw;
    logic lock_missing_raw;

    // Switch and filter controls per state; alignment follows the locked state alone
    always_comb
    begin
        ctl_d.bias_switch_on = (state_d == gmc_pkg::GMC_FREE_MODE) ||
                               (state_d == gmc_pkg::GMC_LOR_FREE);
        ctl_d.filter_hiz = (state_d == gmc_pkg::GMC_LOR_HOLD);
        ctl_d.pfd_enable = (state_d == gmc_pkg::GMC_ACQUIRE) ||
                           (state_d == gmc_pkg::GMC_LOCKED);
        // Alignment to a differing reference format is permitted
        ctl_d.align_enable = (state_d == gmc_pkg::GMC_LOCKED);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ctl_q <= '{bias_switch_on: 1'b1, filter_hiz: 1'b0, pfd_enable: 1'b0,
                       align_enable: 1'b0};
        else
            ctl_q <= ctl_d;
    end

    // Raw flag levels: reference input level and lock state
    assign ref_missing_raw = !REF_PRESENT;
    assign lock_missing_raw = (state_q != gmc_pkg::GMC_LOCKED);

    // Hold-off filters stop short mode flicker reaching the flags
    gmc_flag_filter #(
        .STABLE_CYC(FLAG_STABLE_CYC)
    ) u_ref_flag (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .raw(ref_missing_raw),
        .filt(ref_missing_f)
    );

    gmc_flag_filter #(
        .STABLE_CYC(FLAG_STABLE_CYC)
    ) u_lock_flag (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .raw(lock_missing_raw),
        .filt(lock_missing_f)
    );

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign BIAS_SWITCH_ON = ctl_q.bias_switch_on;
    assign LOOP_FILTER_HIZ = ctl_q.filter_hiz;
    assign PFD_ENABLE = ctl_q.pfd_enable;
    assign ALIGN_ENABLE = ctl_q.align_enable;
    assign REF_MISSING = ref_missing_f;
    assign LOCK_MISSING = lock_missing_f;
endmodule
`default_nettype wire

// file: design/gmc_pkg.sv
// Purpose: Shared constants and types for the genlock mode control block
// Assumes: One 250 MHz clock, APB register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package gmc_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] GMC_OFS_CTRL = 8'h00;
    localparam logic [7:0] GMC_OFS_STAT = 8'h04;
    localparam logic [7:0] GMC_OFS_CFG = 8'h08;
    // Control register fields
    localparam int GMC_CTRL_SRC_BIT = 7;
    localparam int GMC_CTRL_MODE_BIT = 6;
    localparam int GMC_CTRL_HOLD_BIT = 4;
    localparam int GMC_CTRL_XLOCK_BIT = 0;
    // Reset value: register mode source, free run, holdover off
    localparam logic [7:0] GMC_CTRL_RST = 8'h80;
    // Lock qualification time and its cycle count at 250 MHz
    localparam int GMC_CLK_MHZ = 250;
    localparam int GMC_LOCK_QUAL_NS = 1000;
    localparam int GMC_LOCK_QUAL_CYC = (GMC_LOCK_QUAL_NS * GMC_CLK_MHZ) / 1000;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        GMC_FREE_MODE,
        GMC_ACQUIRE,
        GMC_LOCKED,
        GMC_LOR_FREE,
        GMC_LOR_HOLD
    } gmc_state_t;
    // Analog-side switch controls toward the loop
    typedef struct packed {
        logic bias_switch_on;
        logic filter_hiz;
        logic pfd_enable;
        logic align_enable;
    } gmc_loop_ctl_t;
endpackage

// file: design/gmc_flag_filter.sv
// Purpose: Registers a status flag only after it has held steady for a number of cycles
// Assumes: Input synchronous to the clock
// Notes: Keeps brief mode changes from glitching the status flags
`timescale 1ns/1ps
`default_nettype none
module gmc_flag_filter #(
    parameter int STABLE_CYC = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic filt
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic filt_q;
    logic filt_d;

    // Count how long raw differs from the held flag
    always_comb
    begin
        cnt_d = 8'h00;
        filt_d = filt_q;
        if (raw != filt_q)
        begin
            if (cnt_q == 8'(STABLE_CYC - 1))
                filt_d = raw;
            else
                cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            filt_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            filt_q <= filt_d;
        end
    end

    assign filt = filt_q;
endmodule
`default_nettype wire

// file: bench/gmc_assertions.sv
// Purpose: Port-level checks on the mode control block
// Assumes: Sees only top ports; single clock domain
// Notes: Flag lags are bounded generously against the filter length; the reference flag lag is also checked exactly
`timescale 1ns/1ps
`default_nettype none
module gmc_assertions #(
    parameter int FLAG_STABLE_CYC = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic REF_PRESENT,
    input wire logic BIAS_SWITCH_ON,
    input wire logic LOOP_FILTER_HIZ,
    input wire logic PFD_ENABLE,
    input wire logic ALIGN_ENABLE,
    input wire logic REF_MISSING,
    input wire logic LOCK_MISSING
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic [7:0] miss_cnt;

    // Run length of an absent reference, saturating; lets the flag lag be checked exactly
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            miss_cnt <= 8'h00;
        else if (REF_PRESENT)
            miss_cnt <= 8'h00;
        else if (miss_cnt != 8'hff)
            miss_cnt <= miss_cnt + 8'h01;
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    AST_PREADY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready not one cycle after access");
    AST_PREADY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_FREE_BIAS: assert property (BIAS_SWITCH_ON |-> !PFD_ENABLE && !LOOP_FILTER_HIZ)
        else $error("bias switch closed while loop driven");
    AST_ALIGN_LOCK: assert property (ALIGN_ENABLE |-> PFD_ENABLE)
        else $error("alignment without phase detector");
    AST_LOSS_STOPS_PFD: assert property (!REF_PRESENT |=> !PFD_ENABLE)
        else $error("phase detector on without reference");
    AST_HOLD_HIZ: assert property (LOOP_FILTER_HIZ |-> !BIAS_SWITCH_ON && !PFD_ENABLE)
        else $error("holdover with loop driven");
    AST_RETURN: assert property (REF_PRESENT && LOOP_FILTER_HIZ |=> !LOOP_FILTER_HIZ)
        else $error("holdover kept after reference return");
    AST_REF_FLAG: assert property (!REF_PRESENT [*8] |-> REF_MISSING)
        else $error("reference missing flag low");
    AST_REF_LAG: assert property (miss_cnt >= 8'(FLAG_STABLE_CYC) |-> REF_MISSING)
        else $error("reference missing flag later than its hold-off");
    AST_LOCK_FLAG: assert property (ALIGN_ENABLE [*8] |-> !LOCK_MISSING)
        else $error("lock missing flag high while locked");
endmodule
bind gmc_top gmc_assertions #(.FLAG_STABLE_CYC(FLAG_STABLE_CYC)) i_chk (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .REF_PRESENT(REF_PRESENT), .BIAS_SWITCH_ON(BIAS_SWITCH_ON),
    .LOOP_FILTER_HIZ(LOOP_FILTER_HIZ), .PFD_ENABLE(PFD_ENABLE), .ALIGN_ENABLE(ALIGN_ENABLE),
    .REF_MISSING(REF_MISSING), .LOCK_MISSING(LOCK_MISSING));
`default_nettype wire

// file: bench/gmc_ref_model.sv
// Purpose: Reference source and loop lock detector seen by the block
// Assumes: Gated reference reads absent through its pull resistor
// Notes: Lock comes LOCK_CYC cycles after detection starts on a reference
`timescale 1ns/1ps
`default_nettype none
module gmc_ref_model #(
    parameter int LOCK_CYC = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_on,
    input wire logic pfd_en,
    output logic ref_present,
    output logic loop_locked
);
    int cnt;
    // Gating the reference off makes it absent, never stale
    assign ref_present = ref_on;
    // Loop settles only while detection runs, whatever the reference quality
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            cnt <= 0;
        else
            cnt <= !(pfd_en && ref_on) ? 0 : (cnt < LOCK_CYC) ? cnt + 1 : cnt;
    assign loop_locked = (cnt >= LOCK_CYC);
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench for the mode control block
// Assumes: APB master here, reference model on the far side
// Notes: Fixed settle time covers lock and flag filter lags
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_n, psel, pen, pwr, pin, ref_on, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic pready, pslverr, refp, lockd, bias, hiz, pfd, algn, rmiss, lmiss;
    int n_fail, samples_checked, cyc, seed;
    gmc_top #(.FLAG_STABLE_CYC(2)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LOCK_MODE_SELECT_PIN(pin),
        .REF_PRESENT(refp), .LOOP_LOCKED(lockd), .BIAS_SWITCH_ON(bias),
        .LOOP_FILTER_HIZ(hiz), .PFD_ENABLE(pfd), .ALIGN_ENABLE(algn),
        .REF_MISSING(rmiss), .LOCK_MISSING(lmiss));
    gmc_ref_model #(.LOCK_CYC(20)) i_ref (.clk(clk), .rst_n(rst_n), .ref_on(ref_on),
        .pfd_en(pfd), .ref_present(refp), .loop_locked(lockd));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One APB transfer; a spare edge keeps strobes from being set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
            begin
                n_fail++;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
    endtask
    // Outputs and status once settled: mode g, holdover h, reference r
    function automatic logic [31:0] stat_exp(input logic g, input logic h, input logic r);
        logic [2:0] st;
        st = !g ? 3'h0 : r ? 3'h2 : h ? 3'h4 : 3'h3;
        return {(st == 3'h0 || st == 3'h3), st == 3'h4, st == 3'h2, st == 3'h2,
            22'h0, !r, st != 3'h2, g, st};
    endfunction
    task automatic scen(input logic g, input logic h, input logic r);
        logic [31:0] e;
        e = stat_exp(g, h, r);
        ref_on <= r;
        repeat (60) @(posedge clk);
        apb(1'b0, gmc_pkg::GMC_OFS_STAT, 32'h0);
        chk({bias, hiz, pfd, algn, rd[27:0]}, e);
        chk({30'h0, rmiss, lmiss}, {30'h0, e[5:4]});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************************************
    // Clock, reset, timeout and sequence
    // ****************************************************************
    initial
        begin
            clk = 1'b0;
            forever #2 clk = ~clk;
        end
    // Whole sequence needs about 700 cycles
    always @(posedge clk)
        begin
            cyc++;
            if (cyc > 5000)
                begin
                    n_fail++;
                    final_report();
                end
        end
    initial
        begin
            {rst_n, psel, pen, pwr, pin, paddr, pwdata} = '0;
            ref_on = 1'b1;
            seed = 99;
            repeat (4) @(posedge clk);
            rst_n <= 1'b1;
            @(posedge clk);
            apb(1'b0, gmc_pkg::GMC_OFS_CTRL, 32'h0);
            chk(rd, 32'h80);
            scen(1'b0, 1'b0, 1'b1);
            scen(1'b0, 1'b0, 1'b0);
            apb(1'b1, gmc_pkg::GMC_OFS_CTRL, 32'hc0);
            scen(1'b1, 1'b0, 1'b1);
            scen(1'b1, 1'b0, 1'b0);
            scen(1'b1, 1'b0, 1'b1);
            apb(1'b1, gmc_pkg::GMC_OFS_CTRL, 32'hd1);
            scen(1'b1, 1'b1, 1'b0);
            scen(1'b1, 1'b1, 1'b1);
            apb(1'b1, gmc_pkg::GMC_OFS_CTRL, 32'h00);
            pin <= 1'b1;
            scen(1'b1, 1'b0, 1'b1);
            pin <= 1'b0;
            scen(1'b0, 1'b0, 1'b1);
            apb(1'b1, gmc_pkg::GMC_OFS_STAT, 32'hff);
            chk({31'h0, err}, 32'h1);
            apb(1'b1, gmc_pkg::GMC_OFS_CFG, 32'hff);
            chk({31'h0, err}, 32'h1);
            apb(1'b0, gmc_pkg::GMC_OFS_CFG, 32'h0);
            chk(rd, 32'h0);
            repeat (8)
                begin
                    v = $random(seed);
                    pin <= v[9];
                    apb(1'b1, gmc_pkg::GMC_OFS_CTRL, v);
                    apb(1'b0, gmc_pkg::GMC_OFS_CTRL, 32'h0);
                    chk(rd, {24'h0, v[7:0]});
                end
            final_report();
        end
endmodule
`default_nettype wire
